// ---- common/ubc_pkg.sv ----
package ubc_pkg;

    // Register offsets
    localparam logic [7:0] ADDR_POWER_CTRL   = 8'h87;
    localparam logic [7:0] ADDR_TIMER_MODE   = 8'h89;
    localparam logic [7:0] ADDR_T1_RELOAD    = 8'h8d;
    localparam logic [7:0] ADDR_SERIAL_CTRL  = 8'h98;
    localparam logic [7:0] ADDR_SERIAL_BUF   = 8'h99;
    localparam logic [7:0] ADDR_FRACTION     = 8'h9d;
    localparam logic [7:0] ADDR_BAUD_CTRL    = 8'h9e;
    localparam logic [7:0] ADDR_CONFIG       = 8'haf;
    localparam logic [7:0] ADDR_T2_CTRL      = 8'hc8;
    localparam logic [7:0] ADDR_T2_RELOAD_LO = 8'hca;
    localparam logic [7:0] ADDR_T2_RELOAD_HI = 8'hcb;

    // Reset values
    localparam logic [7:0] RST_REG8  = 8'h00;
    localparam logic [7:0] RST_RDATA = 8'h00;

    // Serial control fields
    localparam int SC_MODE_HI   = 7;
    localparam int SC_MODE_LO   = 6;
    localparam int SC_MULTIPROC = 5;
    localparam int SC_RX_EN     = 4;
    localparam int SC_TX_NINTH  = 3;
    localparam int SC_RX_NINTH  = 2;
    localparam int SC_TX_FLAG   = 1;
    localparam int SC_RX_FLAG   = 0;

    // Other fields
    localparam int PC_DOUBLE_RATE = 7;
    localparam int BC_OVERWRITE   = 7;
    localparam int BC_FRAME_ERR   = 6;
    localparam int BC_BREAK_ERR   = 5;
    localparam int CF_ENHANCED    = 0;
    localparam int CF_MODULATE    = 1;
    localparam int CF_UART_TIMER  = 2;
    localparam int T2_RX_SELECT   = 5;
    localparam int T2_TX_SELECT   = 4;
    localparam logic [3:0] T1_AUTORELOAD = 4'h2;

    // Timing counts
    localparam int OVERSAMPLE = 16;
    localparam logic [3:0] MODE0_LAST  = 4'hb;
    localparam logic [3:0] MODE0_HALF  = 4'h6;
    localparam logic [3:0] OVS_LAST    = 4'(OVERSAMPLE - 1);
    localparam logic [3:0] MID_COUNT   = 4'(OVERSAMPLE / 2 - 1);
    localparam logic [7:0] BREAK_TICKS = 8'(9 * OVERSAMPLE);
    localparam logic [6:0] FRAC_UNIT   = 7'h40;

    // Operating modes
    typedef enum logic [1:0] {
        UBC_MODE0 = 2'b00,
        UBC_MODE1 = 2'b01,
        UBC_MODE2 = 2'b10,
        UBC_MODE3 = 2'b11
    } ubc_mode_t;

    // Received frame
    typedef struct packed {
        logic       ninth;
        logic       stop;
        logic [7:0] data;
    } ubc_frame_t;

endpackage

// ---- design/ubc_frac_tick.sv ----
`timescale 1ns/1ns
`default_nettype none

module ubc_frac_tick
    import ubc_pkg::*;
#(
    parameter int ACC_W = 17
) (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rstn_i,
    // Divider setting
    input  wire logic [3:0] exp_i,
    input  wire logic [5:0] frac_i,
    // Oversample tick
    output var  logic       tick_o
);

    logic [ACC_W-1:0] acc_q;
    logic [ACC_W-1:0] thr;
    logic [ACC_W-1:0] nxt;

    // Period of 2^exp * (64 + frac) / 64 clocks per tick
    assign thr = ACC_W'({1'b0, frac_i} + FRAC_UNIT) << exp_i;
    assign nxt = acc_q + ACC_W'(FRAC_UNIT);

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            acc_q  <= '0;
            tick_o <= 1'b0;
        end else if (nxt >= thr) begin
            acc_q  <= nxt - thr;
            tick_o <= 1'b1;
        end else begin
            acc_q  <= nxt;
            tick_o <= 1'b0;
        end
    end

endmodule // ubc_frac_tick

`default_nettype wire

// ---- design/ubc_uart_baud_err.sv ----
`timescale 1ns/1ns
`default_nettype none

module ubc_uart_baud_err
    import ubc_pkg::*;
(
    // Clock and reset
    input  wire logic       CLK_I,
    input  wire logic       RSTN_I,
    // Register port
    input  wire logic [7:0] ADDR_I,
    input  wire logic [7:0] WDATA_I,
    input  wire logic       WR_I,
    input  wire logic       RD_I,
    output var  logic [7:0] RDATA_O,
    // Rate source and carrier
    input  wire logic       T1_OVF_I,
    input  wire logic       CARRIER_I,
    // Serial pins
    input  wire logic       RXD_I,
    output var  logic       RXD_O,
    output var  logic       RXD_OE_N_O,
    output var  logic       TXD_O,
    // Wake-up
    output var  logic       WAKE_O
);

    typedef enum logic [1:0] {
        RX_IDLE  = 2'b00,
        RX_START = 2'b01,
        RX_DATA  = 2'b10
    } ubc_rx_state_t;

    typedef enum logic [1:0] {
        M0_IDLE = 2'b00,
        M0_TX   = 2'b01,
        M0_RX   = 2'b10
    } ubc_m0_state_t;

    logic [7:0]    serial_control_reg_q, power_control_reg_q, timer_mode_reg_q, t1_reload_q, frac_q, baud_q;
    logic [7:0]    cfg_q, t2ctl_q, t2_lo_q, t2_hi_q, rxbuf_q;
    ubc_mode_t     mode;
    logic          enh, dbl, buf_wr, buf_rd;
    logic          ri_set, ti_set, rb8_load, rb8_val, owe_set, fe_set, be_set;
    logic          div2_q, t1_half_q, t1_auto, t1_ovf, t1_tick;
    logic [7:0]    t1_cnt_q;
    logic          t2_on, t2_pre_q, t2_ovf;
    logic [15:0]   t2_cnt_q;
    logic          ut_tick, m2_tick, tx16, rx16;
    logic [3:0]    exp_sum;
    logic          rx_m_q, rx_s_q, rx_prev_q;
    logic [3:0]    tx16_q, rx16_q;
    logic          tx_bit, tx_pend_q, tx_busy_q;
    logic [10:0]   tx_sh_q;
    logic [7:0]    txbuf_q;
    logic [3:0]    tx_left_q;
    ubc_rx_state_t rx_st_q;
    logic [3:0]    rx_bits_q;
    ubc_frame_t    rx_fr_q;
    logic          rx_end, accept;
    logic [7:0]    brk_q;
    ubc_m0_state_t m0_st_q;
    logic [3:0]    m0_cnt_q;
    logic [2:0]    m0_bit_q;
    logic [7:0]    m0_sh_q;
    logic          m0_last;

    assign mode   = ubc_mode_t'({serial_control_reg_q[SC_MODE_HI], serial_control_reg_q[SC_MODE_LO]});
    assign enh    = cfg_q[CF_ENHANCED];
    assign dbl    = power_control_reg_q[PC_DOUBLE_RATE];
    assign buf_wr = WR_I && (ADDR_I == ADDR_SERIAL_BUF);
    assign buf_rd = RD_I && (ADDR_I == ADDR_SERIAL_BUF);

    // Software registers
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            power_control_reg_q      <= RST_REG8;
            timer_mode_reg_q      <= RST_REG8;
            t1_reload_q <= RST_REG8;
            frac_q      <= RST_REG8;
            cfg_q       <= RST_REG8;
            t2ctl_q     <= RST_REG8;
            t2_lo_q     <= RST_REG8;
            t2_hi_q     <= RST_REG8;
        end else if (WR_I) begin
            unique case (ADDR_I)
                ADDR_POWER_CTRL:   power_control_reg_q      <= WDATA_I;
                ADDR_TIMER_MODE:   timer_mode_reg_q      <= WDATA_I;
                ADDR_T1_RELOAD:    t1_reload_q <= WDATA_I;
                ADDR_FRACTION:     frac_q      <= WDATA_I;
                ADDR_CONFIG:       cfg_q       <= WDATA_I;
                ADDR_T2_CTRL:      t2ctl_q     <= WDATA_I;
                ADDR_T2_RELOAD_LO: t2_lo_q     <= WDATA_I;
                ADDR_T2_RELOAD_HI: t2_hi_q     <= WDATA_I;
                default: ;
            endcase
        end
    end

    // Serial control, hardware set wins over software write
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            serial_control_reg_q <= RST_REG8;
        end else begin
            if (WR_I && (ADDR_I == ADDR_SERIAL_CTRL)) begin
                serial_control_reg_q <= WDATA_I;
            end
            if (ri_set) begin
                serial_control_reg_q[SC_RX_FLAG] <= 1'b1;
            end
            if (ti_set) begin
                serial_control_reg_q[SC_TX_FLAG] <= 1'b1;
            end
            if (rb8_load) begin
                serial_control_reg_q[SC_RX_NINTH] <= rb8_val;
            end
        end
    end

    // Baud control: writing zero clears a flag, a new event wins
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            baud_q <= RST_REG8;
        end else begin
            if (WR_I && (ADDR_I == ADDR_BAUD_CTRL)) begin
                baud_q <= {baud_q[7:5] & WDATA_I[7:5], WDATA_I[4:0]};
            end
            if (buf_rd) begin
                baud_q[BC_OVERWRITE] <= 1'b0;
            end
            if (owe_set) begin
                baud_q[BC_OVERWRITE] <= 1'b1;
            end
            if (fe_set) begin
                baud_q[BC_FRAME_ERR] <= 1'b1;
            end
            if (be_set) begin
                baud_q[BC_BREAK_ERR] <= 1'b1;
            end
        end
    end

    // Read port
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            RDATA_O <= RST_RDATA;
        end else if (RD_I) begin
            unique case (ADDR_I)
                ADDR_POWER_CTRL:   RDATA_O <= power_control_reg_q;
                ADDR_TIMER_MODE:   RDATA_O <= timer_mode_reg_q;
                ADDR_T1_RELOAD:    RDATA_O <= t1_reload_q;
                ADDR_SERIAL_CTRL:  RDATA_O <= serial_control_reg_q;
                ADDR_SERIAL_BUF:   RDATA_O <= rxbuf_q;
                ADDR_FRACTION:     RDATA_O <= frac_q;
                ADDR_BAUD_CTRL:    RDATA_O <= baud_q;
                ADDR_CONFIG:       RDATA_O <= cfg_q;
                ADDR_T2_CTRL:      RDATA_O <= t2ctl_q;
                ADDR_T2_RELOAD_LO: RDATA_O <= t2_lo_q;
                ADDR_T2_RELOAD_HI: RDATA_O <= t2_hi_q;
                default:           RDATA_O <= RST_RDATA;
            endcase
        end else begin
            RDATA_O <= RST_RDATA;
        end
    end

    // Timer 1 auto-reload counter and fixed prescalers
    assign t1_auto = (timer_mode_reg_q[7:4] == T1_AUTORELOAD);
    assign t1_ovf  = t1_auto ? (t1_cnt_q == 8'hff) : T1_OVF_I;
    assign t1_tick = t1_ovf && (dbl || t1_half_q);
    assign m2_tick = dbl || div2_q;

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            div2_q    <= 1'b0;
            t1_half_q <= 1'b0;
            t1_cnt_q  <= RST_REG8;
        end else begin
            div2_q <= !div2_q;
            if (t1_ovf) begin
                t1_half_q <= !t1_half_q;
            end
            if (!t1_auto || (t1_cnt_q == 8'hff)) begin
                t1_cnt_q <= t1_reload_q;
            end else begin
                t1_cnt_q <= t1_cnt_q + 8'h01;
            end
        end
    end

    // Timer 2 baud generator
    assign t2_on  = t2ctl_q[T2_TX_SELECT] || t2ctl_q[T2_RX_SELECT];
    assign t2_ovf = t2_on && t2_pre_q && (t2_cnt_q == 16'hffff);

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            t2_pre_q <= 1'b0;
            t2_cnt_q <= 16'h0000;
        end else if (!t2_on) begin
            t2_pre_q <= 1'b0;
            t2_cnt_q <= {t2_hi_q, t2_lo_q};
        end else begin
            t2_pre_q <= !t2_pre_q;
            if (t2_ovf) begin
                t2_cnt_q <= {t2_hi_q, t2_lo_q};
            end else if (t2_pre_q) begin
                t2_cnt_q <= t2_cnt_q + 16'h0001;
            end
        end
    end

    // UART timer
    assign exp_sum = {1'b0, baud_q[2:0]} + {2'b00, baud_q[4:3]};

    ubc_frac_tick u_frac (
        .clk_i  (CLK_I),
        .rstn_i (RSTN_I),
        .exp_i  (exp_sum),
        .frac_i (frac_q[5:0]),
        .tick_o (ut_tick)
    );

    // Oversample tick per direction
    always_comb begin
        if (mode == UBC_MODE2) begin
            tx16 = m2_tick;
            rx16 = m2_tick;
        end else begin
            tx16 = t2ctl_q[T2_TX_SELECT] ? t2_ovf :
                   (cfg_q[CF_UART_TIMER] ? ut_tick : t1_tick);
            rx16 = t2ctl_q[T2_RX_SELECT] ? t2_ovf :
                   (cfg_q[CF_UART_TIMER] ? ut_tick : t1_tick);
        end
    end

    // Receive pin synchroniser and wake-up
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            rx_m_q    <= 1'b1;
            rx_s_q    <= 1'b1;
            rx_prev_q <= 1'b1;
            WAKE_O    <= 1'b0;
        end else begin
            rx_m_q    <= RXD_I;
            rx_s_q    <= rx_m_q;
            rx_prev_q <= rx_s_q;
            WAKE_O    <= rx_prev_q ^ rx_s_q;
        end
    end

    // Transmitter, modes 1 to 3
    assign tx_bit = tx16 && (tx16_q == OVS_LAST);

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            tx16_q    <= 4'h0;
            tx_pend_q <= 1'b0;
            tx_busy_q <= 1'b0;
            tx_sh_q   <= 11'h7ff;
            tx_left_q <= 4'h0;
        end else begin
            if (tx16) begin
                tx16_q <= tx16_q + 4'h1;
            end
            if (buf_wr && (mode != UBC_MODE0)) begin
                tx_pend_q <= 1'b1;
            end
            if (tx_bit && !tx_busy_q && tx_pend_q) begin
                tx_pend_q <= 1'b0;
                tx_busy_q <= 1'b1;
                if (mode == UBC_MODE1) begin
                    tx_sh_q   <= {2'b11, txbuf_q, 1'b0};
                    tx_left_q <= 4'ha;
                end else begin
                    tx_sh_q   <= {1'b1, serial_control_reg_q[SC_TX_NINTH], txbuf_q, 1'b0};
                    tx_left_q <= 4'hb;
                end
            end else if (tx_bit && tx_busy_q) begin
                if (tx_left_q == 4'h1) begin
                    tx_busy_q <= 1'b0;
                end else begin
                    tx_sh_q   <= {1'b1, tx_sh_q[10:1]};
                    tx_left_q <= tx_left_q - 4'h1;
                end
            end
        end
    end

    // Transmit data latched at the buffer write
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            txbuf_q <= RST_REG8;
        end else if (buf_wr) begin
            txbuf_q <= WDATA_I;
        end
    end

    // Receiver, modes 1 to 3
    assign rx_end = (rx_st_q == RX_DATA) && rx16 && (rx16_q == OVS_LAST) &&
                    (rx_bits_q == ((mode == UBC_MODE1) ? 4'h8 : 4'h9));
    assign rb8_val = (mode == UBC_MODE1) ? rx_s_q : rx_fr_q.ninth;
    assign accept  = rx_end && (enh || !serial_control_reg_q[SC_RX_FLAG]) &&
                     (!serial_control_reg_q[SC_MULTIPROC] || rb8_val);
    assign owe_set = accept && enh && serial_control_reg_q[SC_RX_FLAG];
    assign fe_set  = rx_end && enh && !rx_s_q;
    assign rb8_load = accept;

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            rx_st_q   <= RX_IDLE;
            rx16_q    <= 4'h0;
            rx_bits_q <= 4'h0;
            rx_fr_q   <= '0;
        end else begin
            unique case (rx_st_q)
                RX_IDLE: begin
                    rx16_q    <= 4'h0;
                    rx_bits_q <= 4'h0;
                    if (serial_control_reg_q[SC_RX_EN] && (mode != UBC_MODE0) && rx_prev_q && !rx_s_q) begin
                        rx_st_q <= RX_START;
                    end
                end
                RX_START: begin
                    if (rx16) begin
                        rx16_q <= rx16_q + 4'h1;
                        if (rx16_q == MID_COUNT) begin
                            rx16_q  <= 4'h0;
                            rx_st_q <= rx_s_q ? RX_IDLE : RX_DATA;
                        end
                    end
                end
                RX_DATA: begin
                    if (rx16) begin
                        rx16_q <= rx16_q + 4'h1;
                        if (rx16_q == OVS_LAST) begin
                            rx_bits_q <= rx_bits_q + 4'h1;
                            if (rx_bits_q < 4'h8) begin
                                rx_fr_q.data <= {rx_s_q, rx_fr_q.data[7:1]};
                            end else if (!rx_end) begin
                                rx_fr_q.ninth <= rx_s_q;
                            end else begin
                                rx_fr_q.stop <= rx_s_q;
                                rx_st_q      <= RX_IDLE;
                            end
                        end
                    end
                end
                default: rx_st_q <= RX_IDLE;
            endcase
        end
    end

    // Break detection
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            brk_q <= 8'h00;
        end else if (rx_s_q) begin
            brk_q <= 8'h00;
        end else if (rx16 && (brk_q <= BREAK_TICKS)) begin
            brk_q <= brk_q + 8'h01;
        end
    end
    assign be_set = enh && (mode != UBC_MODE0) && !rx_s_q && rx16 &&
                    (brk_q == BREAK_TICKS);

    // Mode 0 shift engine
    assign m0_last = (m0_cnt_q == MODE0_LAST);

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            m0_st_q  <= M0_IDLE;
            m0_cnt_q <= 4'h0;
            m0_bit_q <= 3'h0;
            m0_sh_q  <= RST_REG8;
        end else begin
            unique case (m0_st_q)
                M0_IDLE: begin
                    m0_cnt_q <= 4'h0;
                    m0_bit_q <= 3'h0;
                    if (mode == UBC_MODE0) begin
                        if (buf_wr) begin
                            m0_sh_q <= WDATA_I;
                            m0_st_q <= M0_TX;
                        end else if (serial_control_reg_q[SC_RX_EN] && !serial_control_reg_q[SC_RX_FLAG]) begin
                            m0_st_q <= M0_RX;
                        end
                    end
                end
                M0_TX, M0_RX: begin
                    m0_cnt_q <= m0_last ? 4'h0 : m0_cnt_q + 4'h1;
                    if (m0_last) begin
                        m0_bit_q <= m0_bit_q + 3'h1;
                        m0_sh_q  <= {(m0_st_q == M0_RX) ? rx_s_q : 1'b1, m0_sh_q[7:1]};
                        if (m0_bit_q == 3'h7) begin
                            m0_st_q <= M0_IDLE;
                        end
                    end
                end
                default: m0_st_q <= M0_IDLE;
            endcase
        end
    end

    assign ti_set = (tx_bit && tx_busy_q && (tx_left_q == 4'h2)) ||
                    ((m0_st_q == M0_TX) && m0_last && (m0_bit_q == 3'h7));
    assign ri_set = accept || ((m0_st_q == M0_RX) && m0_last && (m0_bit_q == 3'h7));

    // Receive buffer
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            rxbuf_q <= RST_REG8;
        end else if (accept) begin
            rxbuf_q <= rx_fr_q.data;
        end else if ((m0_st_q == M0_RX) && m0_last && (m0_bit_q == 3'h7)) begin
            rxbuf_q <= {rx_s_q, m0_sh_q[7:1]};
        end
    end

    // Pin drivers
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            TXD_O      <= 1'b1;
            RXD_O      <= 1'b1;
            RXD_OE_N_O <= 1'b1;
        end else begin
            if (mode == UBC_MODE0) begin
                TXD_O <= (m0_st_q == M0_IDLE) || (m0_cnt_q >= MODE0_HALF);
            end else begin
                TXD_O <= (tx_busy_q ? tx_sh_q[0] : 1'b1) ||
                         (cfg_q[CF_MODULATE] && CARRIER_I);
            end
            RXD_O      <= m0_sh_q[0];
            RXD_OE_N_O <= (m0_st_q != M0_TX);
        end
    end

endmodule // ubc_uart_baud_err

`default_nettype wire

// ---- dv/ubc_uart_baud_err_checker.sv ----
`timescale 1ns/1ns
`default_nettype none
module ubc_uart_baud_err_checker
    import ubc_pkg::*;
(
    // Clock and reset
    input wire logic       CLK_I,
    input wire logic       RSTN_I,
    // Register port
    input wire logic [7:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic       WR_I,
    input wire logic       RD_I,
    input wire logic [7:0] RDATA_O,
    // Serial pins
    input wire logic       RXD_I,
    input wire logic       RXD_OE_N_O,
    input wire logic       TXD_O,
    input wire logic       WAKE_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RSTN_I);
    sequence s_wr_rd(logic [7:0] a);
        WR_I && ADDR_I == a ##1 RD_I && ADDR_I == a;
    endsequence
    sequence s_bufrd_baudrd;
        RD_I && ADDR_I == ADDR_SERIAL_BUF ##1 RD_I && ADDR_I == ADDR_BAUD_CTRL;
    endsequence
    property p_rd_idle;
        !$past(RD_I) |-> RDATA_O == 8'h00;
    endproperty
    property p_unmapped;
        RD_I && ADDR_I == 8'h00 |=> RDATA_O == 8'h00;
    endproperty
    property p_frac;
        s_wr_rd(ADDR_FRACTION) |=> RDATA_O[5:0] == 6'($past(WDATA_I, 2));
    endproperty
    property p_t1_reload;
        s_wr_rd(ADDR_T1_RELOAD) |=> RDATA_O == $past(WDATA_I, 2);
    endproperty
    property p_t2_reload;
        s_wr_rd(ADDR_T2_RELOAD_LO) |=> RDATA_O == $past(WDATA_I, 2);
    endproperty
    property p_ovw_clear;
        s_bufrd_baudrd |=> !RDATA_O[BC_OVERWRITE];
    endproperty
    property p_wake;
        $fell(RXD_I) |-> ##[1:4] WAKE_O;
    endproperty
    property p_m0_low;
        $fell(TXD_O) && !RXD_OE_N_O |-> !TXD_O [*6] ##1 TXD_O;
    endproperty
    property p_m0_high;
        $rose(TXD_O) && !RXD_OE_N_O |-> TXD_O [*6];
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read");
    a_frac: assert property (p_frac) else $error("fraction readback");
    a_t1_reload: assert property (p_t1_reload) else $error("t1 reload readback");
    a_t2_reload: assert property (p_t2_reload) else $error("t2 reload readback");
    a_ovw_clear: assert property (p_ovw_clear) else $error("overwrite not cleared");
    a_wake: assert property (p_wake) else $error("no wake pulse");
    a_m0_low: assert property (p_m0_low) else $error("mode0 low phase");
    a_m0_high: assert property (p_m0_high) else $error("mode0 high phase");
endmodule // ubc_uart_baud_err_checker
`default_nettype wire

// ---- dv/ubc_serial_node.sv ----
`timescale 1ns/1ns
`default_nettype none
module ubc_serial_node (
    // Clock
    input  wire logic clk_i,
    // Serial lines
    input  wire logic txd_i,
    output var  logic rxd_o
);
    initial rxd_o = 1'b1;
    // Send bits LSB first, line back to idle high
    task automatic send(input logic [10:0] bits, input int n, input int per);
        for (int i = 0; i < n; i++) begin
            rxd_o <= bits[i];
            repeat (per) @(posedge clk_i);
        end
        rxd_o <= 1'b1;
    endtask
    // Take data and ninth or stop bit at mid-bit
    task automatic take(input int per, output logic [8:0] bits);
        @(negedge txd_i);
        repeat (per / 2) @(posedge clk_i);
        for (int i = 0; i < 9; i++) begin
            repeat (per) @(posedge clk_i);
            bits[i] = txd_i;
        end
        repeat (per) @(posedge clk_i);
    endtask
endmodule // ubc_serial_node
`default_nettype wire

// ---- dv/ubc_uart_baud_err_test.sv ----
`timescale 1ns/1ns
`default_nettype none
module ubc_uart_baud_err_test;
    import ubc_pkg::*;
    logic       clk = 1'b0;
    logic       rstn = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic       wr = 1'b0;
    logic       rd = 1'b0;
    logic       t1_ovf = 1'b0;
    logic       carrier = 1'b0;
    logic [7:0] rdata;
    logic       rxd;
    logic       rxd_o;
    logic       rxd_oe_n;
    logic       txd;
    logic       wake;
    logic [8:0] fr;
    logic [7:0] v;
    int         n_fail = 0;
    int         compares = 0;
    wire        rxd_w = rxd_oe_n ? rxd : rxd_o;
    always #2 clk = ~clk;
    always @(posedge clk) t1_ovf <= ~t1_ovf;
    ubc_uart_baud_err dut (.CLK_I(clk), .RSTN_I(rstn), .ADDR_I(addr), .WDATA_I(wdata),
        .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .T1_OVF_I(t1_ovf), .CARRIER_I(carrier),
        .RXD_I(rxd_w), .RXD_O(rxd_o), .RXD_OE_N_O(rxd_oe_n), .TXD_O(txd), .WAKE_O(wake));
    ubc_serial_node node (.clk_i(clk), .txd_i(txd), .rxd_o(rxd));
    task automatic chk(input string nm, input logic [8:0] exp, input logic [8:0] got);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr8(input logic [7:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    task automatic rd8(input logic [7:0] a, input logic [7:0] exp, input string nm);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(nm, {1'b0, exp}, {1'b0, rdata});
    endtask
    task automatic t_regs();
        rd8(ADDR_SERIAL_CTRL, RST_REG8, "serial_control_reg rst");
        rd8(ADDR_BAUD_CTRL, RST_REG8, "baud rst");
        wr8(ADDR_FRACTION, 8'h2b);
        rd8(ADDR_FRACTION, 8'h2b, "frac");
        wr8(ADDR_T1_RELOAD, 8'hc3);
        rd8(ADDR_T1_RELOAD, 8'hc3, "t1 reload");
        wr8(ADDR_T2_RELOAD_HI, 8'hff);
        wr8(ADDR_T2_RELOAD_LO, 8'hff);
        rd8(ADDR_T2_RELOAD_LO, 8'hff, "t2 reload");
        rd8(8'h00, 8'h00, "unmapped");
        $display("done regs");
    endtask
    task automatic t_mode0();
        wr8(ADDR_SERIAL_BUF, 8'h96);
        for (int i = 0; i < 8; i++) begin
            @(posedge txd);
            v[i] = rxd_o;
        end
        chk("mode0 data", 9'h096, {1'b0, v});
        repeat (30) @(posedge clk);
        wr8(ADDR_SERIAL_CTRL, 8'h10);
        repeat (110) @(posedge clk);
        rd8(ADDR_SERIAL_BUF, 8'hff, "mode0 rx");
        rd8(ADDR_SERIAL_CTRL, 8'h11, "mode0 ri");
        $display("done mode0");
    endtask
    task automatic t_mode2();
        wr8(ADDR_POWER_CTRL, 8'h80);
        wr8(ADDR_SERIAL_CTRL, 8'h88);
        wr8(ADDR_SERIAL_BUF, 8'ha5);
        node.take(16, fr);
        chk("mode2 tx", 9'h1a5, fr);
        wr8(ADDR_SERIAL_CTRL, 8'h90);
        node.send({2'b11, 8'h3c, 1'b0}, 11, 16);
        rd8(ADDR_SERIAL_BUF, 8'h3c, "mode2 rx");
        rd8(ADDR_SERIAL_CTRL, 8'h95, "mode2 serial_control_reg");
        wr8(ADDR_POWER_CTRL, 8'h00);
        wr8(ADDR_SERIAL_CTRL, 8'h40);
        wr8(ADDR_SERIAL_BUF, 8'h5a);
        node.take(64, fr);
        chk("timer1 tx", 9'h15a, fr);
        $display("done mode2 timer1");
    endtask
    task automatic t_enh();
        wr8(ADDR_CONFIG, 8'h05);
        wr8(ADDR_BAUD_CTRL, 8'h01);
        wr8(ADDR_FRACTION, 8'h20);
        wr8(ADDR_SERIAL_CTRL, 8'h50);
        node.send({1'b1, 8'h5a, 1'b0}, 10, 48);
        rd8(ADDR_SERIAL_BUF, 8'h5a, "uart timer rx");
        node.send({1'b1, 8'hc3, 1'b0}, 10, 48);
        rd8(ADDR_SERIAL_BUF, 8'hc3, "overwrite buf");
        rd8(ADDR_BAUD_CTRL, 8'h01, "overwrite clr");
        wr8(ADDR_SERIAL_CTRL, 8'h50);
        node.send({1'b0, 8'hff, 1'b0}, 10, 48);
        repeat (100) @(posedge clk);
        rd8(ADDR_BAUD_CTRL, 8'h41, "frame err");
        wr8(ADDR_BAUD_CTRL, 8'h01);
        wr8(ADDR_SERIAL_CTRL, 8'h50);
        node.send(11'h000, 1, 600);
        repeat (100) @(posedge clk);
        rd8(ADDR_BAUD_CTRL, 8'h61, "break err");
        wr8(ADDR_BAUD_CTRL, 8'h01);
        wr8(ADDR_CONFIG, 8'h04);
        node.send({1'b0, 8'hff, 1'b0}, 10, 48);
        rd8(ADDR_BAUD_CTRL, 8'h01, "no enh err");
        wr8(ADDR_SERIAL_CTRL, 8'h70);
        node.send({1'b0, 8'h11, 1'b0}, 10, 48);
        rd8(ADDR_SERIAL_CTRL, 8'h70, "mp drop");
        node.send({1'b1, 8'h22, 1'b0}, 10, 48);
        rd8(ADDR_SERIAL_CTRL, 8'h75, "mp keep");
        wr8(ADDR_T2_CTRL, 8'h10);
        wr8(ADDR_SERIAL_BUF, 8'h3c);
        node.take(32, fr);
        chk("timer2 tx", 9'h13c, fr);
        carrier <= 1'b1;
        wr8(ADDR_CONFIG, 8'h02);
        wr8(ADDR_SERIAL_BUF, 8'h00);
        fr = 9'h1ff;
        repeat (96) begin
            @(posedge clk);
            fr[0] = fr[0] & txd;
        end
        chk("carrier or", 9'h1ff, fr);
        $display("done enhanced");
    endtask
    task automatic report_and_stop();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        t_regs();
        t_mode0();
        t_mode2();
        t_enh();
        report_and_stop();
    end
    initial begin
        repeat (40000) @(posedge clk);
        n_fail++;
        report_and_stop();
    end
endmodule // ubc_uart_baud_err_test
bind ubc_uart_baud_err ubc_uart_baud_err_checker chk_i (.*);
`default_nettype wire
